// ===== eisa_pkg.sv
// eisa_pkg: constants and types shared by the two-wire slave front end.
// assumes a 40 MHz core clock; the serial clock comes from the bus master.
package eisa_pkg;
   // core clock
   localparam int CLK_PERIOD_NS = 25;
   // input pulse rejection, standard and fast grades
   localparam int GLITCH_STD_NS = 100;
   localparam int GLITCH_FAST_NS = 50;
   localparam int GLITCH_STD_CYC = (GLITCH_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GLITCH_FAST_CYC = (GLITCH_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_W = 3;
   // internal_write_cycle_time, standard and low-voltage parts
   localparam int WR_TIME_STD_MS = 10;
   localparam int WR_TIME_LV_MS = 15;
   localparam int NS_PER_MS = 1000000;
   localparam int WR_CNT_W = 20;
   // byte framing
   localparam int BITS_PER_BYTE = 8;
   localparam logic [3:0] BIT_CNT_FULL = 4'h8;
   localparam logic [1:0] BYTE_SLAVE = 2'h0;
   localparam logic [1:0] BYTE_WORD = 2'h1;
   localparam logic [1:0] BYTE_DATA = 2'h2;
   // slave address fields
   localparam int DTYPE_MSB = 7;
   localparam int DTYPE_LSB = 4;
   localparam int BSEL_MSB = 3;
   localparam int BSEL_LSB = 1;
   localparam int RW_BIT = 0;
   localparam logic RW_READ = 1'b1;
   // bus interface states
   typedef enum logic [2:0] {
      S_IDLE,
      S_RX,
      S_ACK,
      S_TX,
      S_TXACK,
      S_IGNORE,
      S_BUSY
   } eisa_state_t;
endpackage

// ===== eisa_in_filter.sv
// eisa_in_filter: pin synchroniser and pulse rejection for one bus line.
// assumes the input is asynchronous to i_clk and idles high.
`timescale 1ns/10ps
module eisa_in_filter
   import eisa_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_pin,
   input wire logic i_fast_grade,
   output logic o_level
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic [FILT_W-1:0] stab_r;
   logic [FILT_W-1:0] lim;

   ////////////////////////////////////////////////////////////////////////////
   // three-stage synchroniser; first stage feeds only the second
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
      end else begin
         s1_r <= i_pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign lim = i_fast_grade ? FILT_W'(GLITCH_FAST_CYC) : FILT_W'(GLITCH_STD_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // a new level is taken only after it stood for the whole filter time
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         stab_r <= '0;
         o_level <= 1'b1;
      end else if (s2_r != s3_r || s3_r == o_level) begin
         stab_r <= '0; // any bounce restarts the wait
      end else if (stab_r + FILT_W'(1) >= lim) begin
         stab_r <= '0;
         o_level <= s3_r;
      end else begin
         stab_r <= stab_r + FILT_W'(1);
      end
   end
endmodule

// ===== eisa_slave.sv
// eisa_slave: two-wire slave front end of a byte-wide non-volatile memory.
// assumes an open-drain data line with an external pull-up; the array,
// page buffer and read data path sit outside and use the strobes here.
// Summary of operation
// - after a stop that ends a write, the self-timed write finishes within 10 ms or 15 ms.
// - while the write cycle runs the device ignores its address and never acknowledges.
// - during the write cycle the data line is left released and rests high.
// - the addressed receiver acknowledges each byte; a missing one ends the transfer.
// - on writes the device receives and acknowledges, on reads the master does.
// - the master sends type, block select and direction, gets an acknowledge, then the address.
// - three strap inputs form a chip-select code that must match the bus address.
// - pulses on clock and data shorter than 100 ns (50 ns fast grade) are rejected.
// - the first byte holds a 4-bit type, a 3-bit block select and a direction bit.
// - a direction bit of one means read and zero means write.
// - the receiver pulls data low during the ninth clock and then releases it.
// - the byte after the slave address is an 8-bit location in a 256-byte block.
`timescale 1ns/10ps
module eisa_slave
   import eisa_pkg::*;
#(
   parameter logic [3:0] DEV_TYPE = 4'hC, // arbitrary value
   parameter int WR_CYC_STD = WR_TIME_STD_MS * (NS_PER_MS / CLK_PERIOD_NS),
   parameter int WR_CYC_LV = WR_TIME_LV_MS * (NS_PER_MS / CLK_PERIOD_NS)
)
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_scl,
   input wire logic i_sda_in,
   input wire logic i_chip_select_strap_2,
   input wire logic i_chip_select_strap_1,
   input wire logic i_chip_select_strap_0,
   input wire logic i_fast_grade,
   input wire logic i_low_voltage,
   input wire logic [7:0] i_rd_data,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   output logic [7:0] o_word_addr,
   output logic o_addr_valid,
   output logic [7:0] o_wr_data,
   output logic o_wr_strobe,
   output logic o_rd_next,
   output logic o_busy
);
   logic scl_f;
   logic sda_f;
   logic scl_q;
   logic sda_q;
   logic [4:0] st1_r;
   logic [4:0] st2_r;
   logic [4:0] st3_r;
   logic [4:0] strap_r;
   eisa_state_t state_r;
   logic [3:0] bit_cnt_r;
   logic [1:0] byte_cnt_r;
   logic [7:0] sh_r;
   logic rw_r;
   logic mack_r;
   logic wr_pend_r;
   logic [WR_CNT_W-1:0] wr_cnt_r;
   logic [WR_CNT_W-1:0] wr_lim;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic match;
   logic wr_done;

   ////////////////////////////////////////////////////////////////////////////
   // line filters and edge / condition detection
   eisa_in_filter u_scl_filt (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_pin(i_scl),
      .i_fast_grade(strap_r[3]),
      .o_level(scl_f)
   );
   eisa_in_filter u_sda_filt (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_pin(i_sda_in),
      .i_fast_grade(strap_r[3]),
      .o_level(sda_f)
   );

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_f;
         sda_q <= sda_f;
      end
   end

   assign scl_rise = scl_f & ~scl_q;
   assign scl_fall = ~scl_f & scl_q;
   assign start_c = scl_f & scl_q & sda_q & ~sda_f;
   assign stop_c = scl_f & scl_q & ~sda_q & sda_f;

   ////////////////////////////////////////////////////////////////////////////
   // strap pins: three flops, taken once the last two agree; straps are static
   // so a reset value of zero only lasts a few cycles after release
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         st1_r <= '0;
         st2_r <= '0;
         st3_r <= '0;
         strap_r <= '0;
      end else begin
         st1_r <= {i_low_voltage, i_fast_grade, i_chip_select_strap_2,
                   i_chip_select_strap_1, i_chip_select_strap_0};
         st2_r <= st1_r;
         st3_r <= st2_r;
         if (st2_r == st3_r) begin
            strap_r <= st3_r;
         end
      end
   end

   // type and chip select compare against the received first byte
   assign match = (sh_r[DTYPE_MSB:DTYPE_LSB] == DEV_TYPE) &&
                  (sh_r[BSEL_MSB:BSEL_LSB] == strap_r[2:0]);

   ////////////////////////////////////////////////////////////////////////////
   // self-timed write counter; limit picked by the low-voltage strap
   assign wr_lim = strap_r[4] ? WR_CNT_W'(WR_CYC_LV) : WR_CNT_W'(WR_CYC_STD);
   assign wr_done = (wr_cnt_r + WR_CNT_W'(1) >= wr_lim);

   always_ff @(posedge i_clk) begin
      if (!i_reset_n || state_r != S_BUSY) begin
         wr_cnt_r <= '0;
      end else if (!wr_done) begin
         wr_cnt_r <= wr_cnt_r + WR_CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus state machine; start and stop override any byte in flight
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         state_r <= S_IDLE;
         bit_cnt_r <= '0;
         byte_cnt_r <= BYTE_SLAVE;
         sh_r <= '0;
         rw_r <= 1'b0;
         mack_r <= 1'b0;
         wr_pend_r <= 1'b0;
      end else if (state_r == S_BUSY) begin
         if (wr_done) begin
            state_r <= S_IDLE; // bus ignored until here
         end
      end else if (stop_c) begin
         state_r <= wr_pend_r ? S_BUSY : S_IDLE;
         wr_pend_r <= 1'b0;
      end else if (start_c) begin
         state_r <= S_RX;
         bit_cnt_r <= '0;
         byte_cnt_r <= BYTE_SLAVE;
         wr_pend_r <= 1'b0;
      end else begin
         unique case (state_r)
            S_IDLE, S_IGNORE: begin
               bit_cnt_r <= '0; // wait for a start
            end
            S_RX: begin
               if (scl_rise) begin
                  sh_r <= {sh_r[6:0], sda_f};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall && bit_cnt_r == BIT_CNT_FULL) begin
                  if (byte_cnt_r != BYTE_SLAVE) begin
                     state_r <= S_ACK; // device is receiver on writes
                  end else if (match) begin
                     state_r <= S_ACK;
                     rw_r <= (sh_r[RW_BIT] == RW_READ);
                  end else begin
                     state_r <= S_IGNORE;
                  end
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  bit_cnt_r <= '0;
                  if (byte_cnt_r == BYTE_SLAVE && rw_r) begin
                     state_r <= S_TX;
                     sh_r <= i_rd_data;
                  end else begin
                     state_r <= S_RX; // line released after ninth clock
                     if (byte_cnt_r != BYTE_DATA) begin
                        byte_cnt_r <= byte_cnt_r + 2'h1;
                     end
                     if (byte_cnt_r != BYTE_SLAVE) begin
                        wr_pend_r <= (byte_cnt_r == BYTE_DATA) | wr_pend_r;
                     end
                  end
               end
            end
            S_TX: begin
               if (scl_rise) begin
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_r == BIT_CNT_FULL) begin
                     state_r <= S_TXACK;
                  end else begin
                     sh_r <= {sh_r[6:0], 1'b1};
                  end
               end
            end
            S_TXACK: begin
               if (scl_rise) begin
                  mack_r <= ~sda_f;
               end else if (scl_fall) begin
                  bit_cnt_r <= '0;
                  if (mack_r) begin
                     state_r <= S_TX; // master acked, next byte
                     sh_r <= i_rd_data;
                  end else begin
                     state_r <= S_IGNORE; // no ack ends the read
                  end
               end
            end
            S_BUSY: begin
               state_r <= S_BUSY;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // open-drain data pin; output value is held low, only the enable moves
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_sda_out <= 1'b0;
         o_sda_oe_n <= 1'b1;
      end else begin
         o_sda_out <= 1'b0;
         o_sda_oe_n <= !((state_r == S_ACK) ||
                         (state_r == S_TX && !sh_r[7])); // busy releases
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // user-side strobes toward the array and read path
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_word_addr <= '0;
         o_addr_valid <= 1'b0;
         o_wr_data <= '0;
         o_wr_strobe <= 1'b0;
         o_rd_next <= 1'b0;
         o_busy <= 1'b0;
      end else begin
         o_addr_valid <= 1'b0;
         o_wr_strobe <= 1'b0;
         o_rd_next <= 1'b0;
         o_busy <= (state_r == S_BUSY);
         if (state_r == S_ACK && scl_fall && !stop_c && !start_c) begin
            if (byte_cnt_r == BYTE_WORD) begin
               o_word_addr <= sh_r; // location in the selected block
               o_addr_valid <= 1'b1;
            end else if (byte_cnt_r == BYTE_DATA) begin
               o_wr_data <= sh_r;
               o_wr_strobe <= 1'b1;
            end
         end
         o_rd_next <= (state_r == S_TX) && scl_fall && (bit_cnt_r == BIT_CNT_FULL);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_byte_done;
      state_r == S_RX && bit_cnt_r == BIT_CNT_FULL && scl_fall && !start_c && !stop_c;
   endsequence
   sequence s_wr_end;
      state_r == S_BUSY && wr_done;
   endsequence

   busy_release_a: assert property (state_r == S_BUSY && $past(state_r == S_BUSY)
      |-> o_sda_oe_n) else $error("data line driven during write cycle");
   busy_hold_a: assert property (state_r == S_BUSY && !wr_done |=> state_r == S_BUSY)
      else $error("bus answered during write cycle");
   wr_time_a: assert property (state_r == S_BUSY |-> wr_cnt_r < wr_lim)
      else $error("write cycle ran past its limit");
   wr_idle_a: assert property (s_wr_end |=> state_r == S_IDLE ##1 o_sda_oe_n)
      else $error("no return to idle after write");
   addr_ack_a: assert property (s_byte_done ##0 (byte_cnt_r == BYTE_SLAVE && match)
      |=> state_r == S_ACK ##1 !o_sda_oe_n) else $error("address not acked");
   no_match_a: assert property (s_byte_done ##0 (byte_cnt_r == BYTE_SLAVE && !match)
      |=> state_r == S_IGNORE ##1 o_sda_oe_n) else $error("mismatch not ignored");
   rw_read_a: assert property (s_byte_done ##0 (byte_cnt_r == BYTE_SLAVE && match)
      |=> rw_r == $past(sh_r[RW_BIT])) else $error("direction bit misread");
   // on a read the device turns transmitter right after the ninth clock and may pull
   ack_ninth_a: assert property (state_r == S_ACK && scl_fall && !start_c && !stop_c
      |=> state_r != S_ACK ##1 (o_sda_oe_n || state_r == S_TX))
      else $error("ack held past ninth clock");
   word_addr_a: assert property (o_addr_valid |-> o_word_addr == $past(sh_r))
      else $error("word address not from second byte");
   master_nack_a: assert property (state_r == S_TXACK && scl_fall && !mack_r
      && !start_c && !stop_c |=> state_r == S_IGNORE) else $error("nack ignored");
endmodule

// ===== eisa_bus_master.sv
// eisa_bus_master: behavioural two-wire bus master for the slave front end.
// assumes the bench folds both open-drain pulls and the pull-up into i_sda.
`timescale 1ns/10ps
module eisa_bus_master (
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_oe_n
);
   // quarter step: 400 ns low phase leaves room for the slave's filter lag
   localparam int STEP_NS = 100;
   int glitch_ns = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // idle bus: clock high, data released
   initial begin
      o_scl = 1'b1;
      o_sda_oe_n = 1'b1;
   end
   // one clock: data set 200 ns after the fall, sampled in the middle of high
   task automatic clk_bit(input logic drv, output logic smp);
      o_sda_oe_n = drv;
      if (glitch_ns > 0) begin
         #(STEP_NS);
         o_scl = 1'b1; // runt pulse shorter than the rejection time
         #(glitch_ns);
         o_scl = 1'b0;
         #(STEP_NS - glitch_ns);
      end else begin
         #(2 * STEP_NS);
      end
      o_scl = 1'b1;
      #(STEP_NS);
      smp = i_sda;
      #(STEP_NS);
      o_scl = 1'b0;
      #(2 * STEP_NS);
   endtask
   // start, also used as a repeated start from the low phase
   task automatic start_c();
      o_sda_oe_n = 1'b1;
      #(2 * STEP_NS);
      o_scl = 1'b1;
      #(2 * STEP_NS);
      o_sda_oe_n = 1'b0;
      #(2 * STEP_NS);
      o_scl = 1'b0;
      #(2 * STEP_NS);
   endtask
   // stop ends every transaction; the bus is left idle
   task automatic stop_c();
      o_sda_oe_n = 1'b0;
      #(2 * STEP_NS);
      o_scl = 1'b1;
      #(2 * STEP_NS);
      o_sda_oe_n = 1'b1;
      #(4 * STEP_NS);
   endtask
   // byte out msb first, then release the line for the ninth clock
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic x;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], x);
      end
      clk_bit(1'b1, ack);
   endtask
   // byte in; the master acknowledges to go on or withholds it to end
   task automatic get_byte(output logic [7:0] d, input logic nack);
      logic x;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, d[i]);
      end
      clk_bit(nack, x);
   endtask
endmodule

// ===== tb.sv
// tb: self-checking bench for the two-wire slave front end.
// assumes eisa_slave with shortened write cycle counts and a pulled-up data wire.
`timescale 1ns/10ps
module tb;
   localparam logic [3:0] DTYPE = 4'h6; // arbitrary value
   localparam logic [7:0] WR_ADDR = 8'h6A; // type 6, straps 101, write
   localparam logic [7:0] RD_ADDR = 8'h6B;
   localparam int CYC_LIMIT = 20000;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_fast_grade = 1'b0;
   logic i_low_voltage = 1'b0;
   logic [2:0] strap = 3'h5;
   logic [7:0] i_rd_data = 8'h96;
   logic m_scl, m_oe_n, sda_wire, ack;
   logic o_sda_out, o_sda_oe_n, o_addr_valid, o_wr_strobe, o_rd_next, o_busy;
   logic [7:0] o_word_addr, o_wr_data, first_wr, d;
   int errors = 0;
   int checks = 0;
   int cyc = 0;
   int busy_cyc = 0;
   int busy_drv = 0;
   int wr_cnt = 0;
   int addr_cnt = 0;
   int rd_cnt = 0;
   // rows: {expected ack level, slave address}; only row 0 names this device
   logic [8:0] rows [7] = '{9'h06A, 9'h1EA, 9'h12A, 9'h17A, 9'h168, 9'h16E, 9'h162};
   ////////////////////////////////////////////////////////////////////////////////
   always #12.5 i_clk = ~i_clk;
   // wired-AND of both pulls with the pull-up
   assign sda_wire = m_oe_n & (o_sda_oe_n | o_sda_out);
   // read data follows the transmit count so consecutive bytes differ
   always @(negedge i_clk) i_rd_data <= rd_cnt[0] ? 8'h3C : 8'h96;
   eisa_bus_master mdl_u (.i_sda(sda_wire), .o_scl(m_scl), .o_sda_oe_n(m_oe_n));
   eisa_slave #(.DEV_TYPE(DTYPE), .WR_CYC_STD(400), .WR_CYC_LV(600)) dut_u (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(m_scl), .i_sda_in(sda_wire),
      .i_chip_select_strap_2(strap[2]), .i_chip_select_strap_1(strap[1]),
      .i_chip_select_strap_0(strap[0]), .i_fast_grade(i_fast_grade),
      .i_low_voltage(i_low_voltage), .i_rd_data(i_rd_data), .o_sda_out(o_sda_out),
      .o_sda_oe_n(o_sda_oe_n), .o_word_addr(o_word_addr), .o_addr_valid(o_addr_valid),
      .o_wr_data(o_wr_data), .o_wr_strobe(o_wr_strobe), .o_rd_next(o_rd_next),
      .o_busy(o_busy));
   ////////////////////////////////////////////////////////////////////////////////
   // watch pulses and the write cycle; a hung run is cut short here
   always @(posedge i_clk) begin
      cyc++;
      if (o_busy === 1'b1) busy_cyc++;
      if (o_busy === 1'b1 && o_sda_oe_n !== 1'b1) busy_drv++;
      if (o_wr_strobe === 1'b1 && wr_cnt == 0) first_wr = o_wr_data;
      if (o_wr_strobe === 1'b1) wr_cnt++;
      if (o_addr_valid === 1'b1) addr_cnt++;
      if (o_rd_next === 1'b1) rd_cnt++;
      if (cyc == CYC_LIMIT) begin
         errors++;
         test_done();
      end
   end
   task automatic chk_bit(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_count(input string n, input int e, input int g);
      checks++;
      if (g != e) begin
         errors++;
         $display("wrong value %s expected %0d seen %0d", n, e, g);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // straps are resampled every cycle; strap changes still go through a reset here
   task automatic do_reset();
      i_reset_n = 1'b0;
      repeat (6) @(negedge i_clk);
      i_reset_n = 1'b1;
      repeat (10) @(negedge i_clk);
   endtask
   // one byte from the master with the ack level expected back
   task automatic send(input logic [7:0] b, input logic e);
      mdl_u.put_byte(b, ack);
      chk_bit("ack", e, ack);
   endtask
   // two-byte write, refused access while busy, then the device answers again
   task automatic wr_seq(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
                         input int len);
      busy_cyc = 0;
      busy_drv = 0;
      wr_cnt = 0;
      mdl_u.start_c();
      send(WR_ADDR, 1'b0);
      send(a, 1'b0);
      send(d0, 1'b0);
      send(d1, 1'b0);
      mdl_u.stop_c();
      chk_count("data strobes", 2, wr_cnt);
      chk_byte("first data", d0, first_wr);
      chk_byte("last data", d1, o_wr_data);
      chk_byte("word addr", a, o_word_addr);
      chk_bit("busy", 1'b1, o_busy);
      mdl_u.start_c();
      send(WR_ADDR, 1'b1);
      mdl_u.stop_c();
      for (int i = 0; i < 1000 && o_busy === 1'b1; i++) @(negedge i_clk);
      chk_count("busy cycles", len, busy_cyc);
      chk_count("drive while busy", 0, busy_drv);
      mdl_u.start_c();
      send(WR_ADDR, 1'b0);
      mdl_u.stop_c();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      do_reset();
      chk_bit("sda enable", 1'b1, o_sda_oe_n);
      chk_bit("sda out", 1'b0, o_sda_out);
      for (int r = 0; r < 7; r++) begin
         mdl_u.start_c();
         send(rows[r][7:0], rows[r][8]);
         send(8'h40 + 8'(r), rows[r][8]);
         mdl_u.stop_c();
      end
      chk_byte("word addr", 8'h40, o_word_addr);
      chk_count("addr pulses", 1, addr_cnt);
      chk_bit("busy", 1'b0, o_busy);
      wr_seq(8'h5C, 8'hA5, 8'h5A, 400);
      // random read through a repeated start, with runt clock pulses
      mdl_u.glitch_ns = 75;
      mdl_u.start_c();
      send(WR_ADDR, 1'b0);
      send(8'h10, 1'b0);
      mdl_u.start_c();
      send(RD_ADDR, 1'b0);
      mdl_u.get_byte(d, 1'b0);
      chk_byte("read byte", 8'h96, d);
      mdl_u.get_byte(d, 1'b1);
      chk_byte("read byte", 8'h3C, d);
      mdl_u.stop_c();
      chk_count("read pulses", 2, rd_cnt);
      chk_byte("word addr", 8'h10, o_word_addr);
      // fast grade and low-voltage write cycle after a mid-run reset
      i_fast_grade = 1'b1;
      i_low_voltage = 1'b1;
      mdl_u.glitch_ns = 25;
      do_reset();
      chk_bit("busy", 1'b0, o_busy);
      wr_seq(8'hF0, 8'h00, 8'hFF, 600);
      // other strap code: the old address is refused, the new one answered
      strap = 3'h2;
      do_reset();
      mdl_u.start_c();
      send(8'h64, 1'b0);
      mdl_u.stop_c();
      mdl_u.start_c();
      send(WR_ADDR, 1'b1);
      mdl_u.stop_c();
      test_done();
   end
endmodule
